// File: hw/dual_level_interrupt_controller.sv
// Two-path interrupt controller with AHB-Lite register slave
// Behaviour
// RULE_01 - Twenty-three sources, each with its own independent mask bit; the code ignores enable bit 1, so software is unmasked.
// RULE_02 - Fixed bit per source: 1 software, 2-22 peripherals and pins.
// RULE_03 - Bit 23 is motor trip on normal side, motor sync on fast.
// RULE_04 - Normal status is read-only raw AND enable, resets to zero.
// RULE_05 - Normal request output is OR of all 32 normal status bits.
// RULE_06 - No priority or vectors; software reads status to find source.
// RULE_07 - Raw signal bit follows its source request regardless of masks.
// RULE_08 - Normal enable bit 1 allows source, 0 masks it.
// RULE_09 - Normal clear write clears enable bits written as one only.
// RULE_10 - Fast path has identical status, raw, enable and clear registers.
// RULE_11 - Fast request output is OR of fast status bits 31 to 1.
// RULE_12 - Setting a fast enable bit clears the same normal enable bit.
// RULE_13 - Setting a normal enable bit clears the same fast enable bit.
// RULE_14 - A source may be masked on both paths at once.
// RULE_15 - Software requests are unmaskable; set only by config writes.
// RULE_16 - Config bit 1 sets or clears normal status and raw bit 1.
// RULE_17 - Config bit 2 sets or clears fast bit 1; other bits reserved.
// RULE_18 - Sources hold requests at least one controller latency.
// RULE_19 - Handlers confirm slow timer requests dropped by reading status.
// RULE_20 - Requests are level inputs registered into raw before use.
//
// The AHB-Lite slave port was chosen for this implementation.
`include "intc_map.svh"

module dual_level_interrupt_controller
(
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic HRESP,
	output logic [31:0] HRDATA,
	input wire logic [`PERIPH_COUNT-1:0] PERIPH_REQ,
	input wire logic MOTOR_TRIP,
	input wire logic MOTOR_SYNC,
	output logic NORMAL_IRQ,
	output logic FAST_IRQ
);
	import intc_pkg::*;

	// ==========================================
	// Reset image
	localparam intc_state_t RESET_STATE = '{
		norm_raw: `STATUS_RESET,
		fast_raw: `STATUS_RESET,
		norm_en: `ENABLE_RESET,
		fast_en: `ENABLE_RESET,
		sw_norm: 1'b0,
		sw_fast: 1'b0,
		op: ACC_IDLE,
		addr: 32'h00000000,
		rdata: `RDATA_RESET,
		hready: 1'b1,
		hresp: 1'b0,
		norm_out: 1'b0,
		fast_out: 1'b0
	};

	intc_state_t s_reg;
	intc_state_t s_next;
	logic [31:0] norm_sta;
	logic [31:0] fast_sta;
	logic addr_take;

	// ==========================================
	// Helpers
	function automatic logic [31:0] build_raw(
		input logic [`PERIPH_COUNT-1:0] periph,
		input logic motor,
		input logic sw,
		input logic fiq_src);
		logic [31:0] r;
		r = 32'h00000000;
		r[`SRC_FIQ_BIT] = fiq_src;
		r[`SRC_SWI_BIT] = sw;
		r[`SRC_PERIPH_HI:`SRC_PERIPH_LO] = periph;
		r[`SRC_MOTOR_BIT] = motor;
		return r;
	endfunction

	function automatic logic [31:0] status_of(
		input logic [31:0] raw,
		input logic [31:0] en,
		input logic sw);
		logic [31:0] st;
		st = raw & en;
		st[`SRC_SWI_BIT] = sw;
		return st;
	endfunction

	function automatic logic write_hit(
		input access_t op,
		input logic [31:0] addr,
		input logic [31:0] target);
		return (op == ACC_WRITE) && (addr == target);
	endfunction

	function automatic logic read_done_at(
		input access_t op,
		input logic [31:0] addr,
		input logic [31:0] target);
		return (op == ACC_READ_DONE) && (addr == target);
	endfunction

	// ==========================================
	// Status views
	// Status is raw AND enable, software bit unmaskable [RULE_04] [RULE_15]
	assign norm_sta = status_of(s_reg.norm_raw, s_reg.norm_en, s_reg.sw_norm);
	// Same structure on the fast side [RULE_10]
	assign fast_sta = status_of(s_reg.fast_raw, s_reg.fast_en, s_reg.sw_fast);

	assign addr_take = HSEL & HREADY & HTRANS[1] & s_reg.hready;

	// ==========================================
	// Next state
	always_comb
	begin
		s_next = s_reg;
		// Level requests registered each clock [RULE_20] [RULE_07]
		// Motor trip on normal side, sync on fast side [RULE_02] [RULE_03]
		s_next.norm_raw = build_raw(PERIPH_REQ, MOTOR_TRIP, s_reg.sw_norm,
			s_reg.fast_out); // [RULE_01]
		s_next.fast_raw = build_raw(PERIPH_REQ, MOTOR_SYNC, s_reg.sw_fast,
			s_reg.fast_out);
		// Request lines are ORs of status, no encoding [RULE_05] [RULE_06]
		s_next.norm_out = |norm_sta;
		s_next.fast_out = |fast_sta[31:1]; // [RULE_11]
		s_next.hresp = 1'b0;
		case (s_reg.op)
			ACC_WRITE:
			begin
				s_next.op = ACC_IDLE;
				case (s_reg.addr)
					`NORMAL_ENABLE_MASK_ADDR:
					begin
						s_next.norm_en = HWDATA; // [RULE_08]
						s_next.fast_en = s_reg.fast_en & ~HWDATA; // [RULE_13]
					end
					`NORMAL_ENABLE_CLEAR_ADDR:
					begin
						s_next.norm_en = s_reg.norm_en & ~HWDATA; // [RULE_09] [RULE_14]
					end
					`FAST_ENABLE_MASK_ADDR:
					begin
						s_next.fast_en = HWDATA; // [RULE_10]
						s_next.norm_en = s_reg.norm_en & ~HWDATA; // [RULE_12]
					end
					`FAST_ENABLE_CLEAR_ADDR:
					begin
						s_next.fast_en = s_reg.fast_en & ~HWDATA; // [RULE_10] [RULE_14]
					end
					`SOFTWARE_INTERRUPT_CONFIG_ADDR:
					begin
						s_next.sw_norm = HWDATA[`SOFTWARE_INTERRUPT_CONFIG_NORMAL_BIT]; // [RULE_16]
						s_next.sw_fast = HWDATA[`SOFTWARE_INTERRUPT_CONFIG_FAST_BIT]; // [RULE_17]
					end
					default:
					begin
						s_next.op = ACC_IDLE;
					end
				endcase
			end
			ACC_READ_WAIT:
			begin
				s_next.op = ACC_READ_DONE;
				s_next.hready = 1'b1;
				case (s_reg.addr)
					`NORMAL_PENDING_STATUS_ADDR: s_next.rdata = norm_sta;
					`NORMAL_RAW_SIGNAL_ADDR: s_next.rdata = s_reg.norm_raw;
					`NORMAL_ENABLE_MASK_ADDR: s_next.rdata = s_reg.norm_en;
					`FAST_PENDING_STATUS_ADDR: s_next.rdata = fast_sta;
					`FAST_RAW_SIGNAL_ADDR: s_next.rdata = s_reg.fast_raw;
					`FAST_ENABLE_MASK_ADDR: s_next.rdata = s_reg.fast_en;
					default: s_next.rdata = `RDATA_RESET;
				endcase
			end
			ACC_READ_DONE:
			begin
				s_next.op = ACC_IDLE;
			end
			default:
			begin
				s_next.op = ACC_IDLE;
			end
		endcase
		// New address phase; reads take one wait state
		if (addr_take)
		begin
			s_next.addr = HADDR;
			if (HWRITE)
			begin
				s_next.op = ACC_WRITE;
			end
			else
			begin
				s_next.op = ACC_READ_WAIT;
				s_next.hready = 1'b0;
			end
		end
	end

	// ==========================================
	// State register
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			s_reg <= RESET_STATE;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign HREADYOUT = s_reg.hready;
	assign HRESP = s_reg.hresp;
	assign HRDATA = s_reg.rdata;
	assign NORMAL_IRQ = s_reg.norm_out;
	assign FAST_IRQ = s_reg.fast_out;

	// ==========================================
	// Checks
	a_norm_or_out: assert property ( // [RULE_05]
		@(posedge SYS_CLK) disable iff (RST)
		##1 NORMAL_IRQ == (|$past(norm_sta)))
		else $error("normal request not OR of status");

	a_fast_or_out: assert property ( // [RULE_11]
		@(posedge SYS_CLK) disable iff (RST)
		(|fast_sta[31:1]) |=> FAST_IRQ)
		else $error("fast request missing");

	a_raw_follow: assert property ( // [RULE_07]
		@(posedge SYS_CLK) disable iff (RST)
		##1 s_reg.norm_raw[22:2] == $past(PERIPH_REQ)
		&& s_reg.fast_raw[23] == $past(MOTOR_SYNC))
		else $error("raw signal does not follow request");

	a_norm_status_rd: assert property ( // [RULE_04]
		@(posedge SYS_CLK) disable iff (RST)
		read_done_at(s_reg.op, s_reg.addr, `NORMAL_PENDING_STATUS_ADDR)
		|-> HRDATA[31:2] == ($past(s_reg.norm_raw[31:2])
		& $past(s_reg.norm_en[31:2]))
		&& HRDATA[1] == $past(s_reg.sw_norm))
		else $error("normal status read wrong");

	a_en_exclusive: assert property ( // [RULE_12]
		@(posedge SYS_CLK) disable iff (RST)
		(s_reg.op == ACC_WRITE && s_reg.addr == `FAST_ENABLE_MASK_ADDR)
		|=> (s_reg.norm_en & $past(HWDATA)) == 32'h00000000
		&& s_reg.fast_en == $past(HWDATA))
		else $error("fast enable write did not clear normal");

	a_norm_en_wr: assert property ( // [RULE_13]
		@(posedge SYS_CLK) disable iff (RST)
		(s_reg.op == ACC_WRITE && s_reg.addr == `NORMAL_ENABLE_MASK_ADDR)
		|=> s_reg.norm_en == $past(HWDATA)
		&& (s_reg.fast_en & $past(HWDATA)) == 32'h00000000)
		else $error("normal enable write wrong");

	a_clear_keeps: assert property ( // [RULE_09]
		@(posedge SYS_CLK) disable iff (RST)
		(s_reg.op == ACC_WRITE && s_reg.addr == `NORMAL_ENABLE_CLEAR_ADDR)
		|=> s_reg.norm_en == ($past(s_reg.norm_en) & ~$past(HWDATA)))
		else $error("enable clear wrong");

	a_swi_status: assert property ( // [RULE_16]
		@(posedge SYS_CLK) disable iff (RST)
		write_hit(s_reg.op, s_reg.addr, `SOFTWARE_INTERRUPT_CONFIG_ADDR)
		|=> norm_sta[1] == $past(HWDATA[1])
		##1 s_reg.norm_raw[1] == $past(norm_sta[1]))
		else $error("software interrupt not applied");

	a_swi_fast: assert property ( // [RULE_17]
		@(posedge SYS_CLK) disable iff (RST)
		write_hit(s_reg.op, s_reg.addr, `SOFTWARE_INTERRUPT_CONFIG_ADDR)
		|=> fast_sta[1] == $past(HWDATA[2])
		##1 s_reg.fast_raw[1] == $past(fast_sta[1])
		&& FAST_IRQ == $past(|fast_sta[31:1]))
		else $error("fast software interrupt not applied");

	a_read_wait: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(addr_take && !HWRITE) |=> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait state wrong");

	a_raw_motor_trip: assert property ( // [RULE_03]
		@(posedge SYS_CLK) disable iff (RST)
		##1 s_reg.norm_raw[23] == $past(MOTOR_TRIP)
		&& s_reg.fast_raw[22:2] == $past(PERIPH_REQ))
		else $error("trip or fast raw bits wrong");

	a_raw_fiq_bit: assert property ( // [RULE_11]
		@(posedge SYS_CLK) disable iff (RST)
		##1 s_reg.norm_raw[0] == $past(FAST_IRQ)
		&& s_reg.fast_raw[0] == $past(FAST_IRQ))
		else $error("fast request not mirrored in bit 0");

	a_en_disjoint: assert property ( // [RULE_12]
		@(posedge SYS_CLK) disable iff (RST)
		(s_reg.norm_en & s_reg.fast_en) == 32'h00000000)
		else $error("source enabled on both paths");

	a_fast_clear: assert property ( // [RULE_10]
		@(posedge SYS_CLK) disable iff (RST)
		write_hit(s_reg.op, s_reg.addr, `FAST_ENABLE_CLEAR_ADDR)
		|=> s_reg.fast_en == ($past(s_reg.fast_en) & ~$past(HWDATA))
		&& s_reg.norm_en == $past(s_reg.norm_en))
		else $error("fast enable clear wrong");

	a_clear_other: assert property ( // [RULE_14]
		@(posedge SYS_CLK) disable iff (RST)
		write_hit(s_reg.op, s_reg.addr, `NORMAL_ENABLE_CLEAR_ADDR)
		|=> s_reg.fast_en == $past(s_reg.fast_en))
		else $error("normal clear touched fast enables");

	a_status_ro: assert property ( // [RULE_04]
		@(posedge SYS_CLK) disable iff (RST)
		(write_hit(s_reg.op, s_reg.addr, `NORMAL_PENDING_STATUS_ADDR)
		|| write_hit(s_reg.op, s_reg.addr, `FAST_PENDING_STATUS_ADDR))
		|=> s_reg.norm_en == $past(s_reg.norm_en)
		&& s_reg.fast_en == $past(s_reg.fast_en)
		&& s_reg.sw_norm == $past(s_reg.sw_norm))
		else $error("status register took a write");

	a_swi_unmask: assert property ( // [RULE_15]
		@(posedge SYS_CLK) disable iff (RST)
		s_reg.sw_norm |=> NORMAL_IRQ)
		else $error("software request masked on normal path");

	a_swi_fast_unmask: assert property ( // [RULE_15]
		@(posedge SYS_CLK) disable iff (RST)
		s_reg.sw_fast |=> FAST_IRQ)
		else $error("software request masked on fast path");

	a_fast_status_rd: assert property ( // [RULE_10]
		@(posedge SYS_CLK) disable iff (RST)
		read_done_at(s_reg.op, s_reg.addr, `FAST_PENDING_STATUS_ADDR)
		|-> HRDATA[31:2] == ($past(s_reg.fast_raw[31:2])
		& $past(s_reg.fast_en[31:2]))
		&& HRDATA[1] == $past(s_reg.sw_fast))
		else $error("fast status read wrong");

	a_clear_reads_zero: assert property ( // [RULE_09]
		@(posedge SYS_CLK) disable iff (RST)
		read_done_at(s_reg.op, s_reg.addr, `NORMAL_ENABLE_CLEAR_ADDR)
		|-> HRDATA == `RDATA_RESET)
		else $error("write-only register read not zero");

	a_write_no_wait: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(addr_take && HWRITE) |=> HREADYOUT)
		else $error("write inserted a wait state");

	a_resp_okay: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		!HRESP)
		else $error("response not okay");

	a_read_hold: assert property (
		@(posedge SYS_CLK) disable iff (RST)
		(s_reg.op != ACC_READ_WAIT) |=> $stable(HRDATA))
		else $error("read data changed without a read");

	a_reset_clean: assert property ( // [RULE_04]
		@(posedge SYS_CLK) disable iff (RST)
		$fell(RST) |-> s_reg.norm_en == `ENABLE_RESET
		&& s_reg.fast_en == `ENABLE_RESET
		&& HRDATA == `RDATA_RESET && HREADYOUT
		&& !NORMAL_IRQ && !FAST_IRQ)
		else $error("state not clean after reset");

endmodule

// File: pkg/intc_map.svh
// Register offsets, field positions and reset values of the controller
`ifndef INTC_MAP_SVH
`define INTC_MAP_SVH

// ==========================================
// Register byte addresses
`define NORMAL_PENDING_STATUS_ADDR 32'hFFFF0000
`define NORMAL_RAW_SIGNAL_ADDR 32'hFFFF0004
`define NORMAL_ENABLE_MASK_ADDR 32'hFFFF0008
`define NORMAL_ENABLE_CLEAR_ADDR 32'hFFFF000C
`define SOFTWARE_INTERRUPT_CONFIG_ADDR 32'hFFFF0010
`define FAST_PENDING_STATUS_ADDR 32'hFFFF0100
`define FAST_RAW_SIGNAL_ADDR 32'hFFFF0104
`define FAST_ENABLE_MASK_ADDR 32'hFFFF0108
`define FAST_ENABLE_CLEAR_ADDR 32'hFFFF010C

// ==========================================
// Reset values
`define STATUS_RESET 32'h00000000
`define ENABLE_RESET 32'h00000000
`define RDATA_RESET 32'h00000000

// ==========================================
// Field positions
`define SRC_FIQ_BIT 0
`define SRC_SWI_BIT 1
`define SRC_PERIPH_LO 2
`define SRC_PERIPH_HI 22
`define SRC_MOTOR_BIT 23
`define SOFTWARE_INTERRUPT_CONFIG_NORMAL_BIT 1
`define SOFTWARE_INTERRUPT_CONFIG_FAST_BIT 2
`define PERIPH_COUNT 21

`endif

// File: pkg/intc_pkg.sv
// Types shared by the interrupt controller
package intc_pkg;

	// ==========================================
	// Bus access phase
	typedef enum logic [1:0]
	{
		ACC_IDLE = 2'b00,
		ACC_WRITE = 2'b01,
		ACC_READ_WAIT = 2'b10,
		ACC_READ_DONE = 2'b11
	} access_t;

	// ==========================================
	// Whole state of the controller
	typedef struct packed
	{
		logic [31:0] norm_raw;
		logic [31:0] fast_raw;
		logic [31:0] norm_en;
		logic [31:0] fast_en;
		logic sw_norm;
		logic sw_fast;
		access_t op;
		logic [31:0] addr;
		logic [31:0] rdata;
		logic hready;
		logic hresp;
		logic norm_out;
		logic fast_out;
	} intc_state_t;

endpackage

// File: sim/core_irq_model.sv
// Model of the core's normal and fast interrupt inputs
module core_irq_model
(
	input wire logic clk,
	input wire logic rst,
	input wire logic normal_req,
	input wire logic fast_req,
	output logic normal_seen_reg,
	output logic fast_seen_reg
);
	timeunit 1ns;
	timeprecision 1ns;
	// ========
	// Core samples both level lines each clock; no vector is fetched
	always_ff @(posedge clk)
	begin
		normal_seen_reg <= rst ? 1'b0 : normal_req;
		fast_seen_reg <= rst ? 1'b0 : fast_req;
	end
endmodule

// File: sim/dual_level_interrupt_controller_bench.sv
// Register-level bench for the two-path interrupt controller
`include "intc_map.svh"
module dual_level_interrupt_controller_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, hwrite = 0, trip = 0, sync = 0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 0, hwdata = 0;
	logic [20:0] periph = 0;
	logic hready, hresp, nirq, firq, nseen, fseen;
	logic [31:0] hrdata;
	int err_count = 0, samples_checked = 0, cycles = 0;
	dual_level_interrupt_controller uut (.SYS_CLK(clk), .RST(rst),
		.HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
		.HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata),
		.PERIPH_REQ(periph), .MOTOR_TRIP(trip), .MOTOR_SYNC(sync),
		.NORMAL_IRQ(nirq), .FAST_IRQ(firq));
	core_irq_model model (.clk(clk), .rst(rst), .normal_req(nirq),
		.fast_req(firq), .normal_seen_reg(nseen), .fast_seen_reg(fseen));
	// ========
	// Clock, timeout and helpers
	initial
	begin
		forever #20 clk = ~clk;
	end
	task automatic stop_test;
		if (err_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_count++;
			$display("MISMATCH %0t timeout", $time);
			stop_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// ========
	// AHB-Lite single word transfers
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d, output logic [31:0] q);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		q = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk(q, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask
	// ========
	// Test sequence
	initial
	begin
		tick(20);
		rst <= 1'b0;
		tick(1);
		rd(`NORMAL_PENDING_STATUS_ADDR, 32'h0);
		rd(`NORMAL_ENABLE_MASK_ADDR, 32'h0);
		rd(`FAST_ENABLE_MASK_ADDR, 32'h0);
		wr(`NORMAL_ENABLE_MASK_ADDR, 32'h20);
		periph <= 21'h8;
		tick(3);
		rd(`NORMAL_PENDING_STATUS_ADDR, 32'h20);
		rd(`NORMAL_RAW_SIGNAL_ADDR, 32'h20);
		chk({30'h0, nirq, nseen}, 32'h3);
		wr(`FAST_ENABLE_MASK_ADDR, 32'h20);
		tick(2);
		rd(`NORMAL_ENABLE_MASK_ADDR, 32'h0);
		rd(`FAST_PENDING_STATUS_ADDR, 32'h20);
		chk({30'h0, nirq, firq}, 32'h1);
		wr(`NORMAL_ENABLE_MASK_ADDR, 32'h28);
		tick(2);
		rd(`FAST_ENABLE_MASK_ADDR, 32'h0);
		wr(`NORMAL_ENABLE_CLEAR_ADDR, 32'h20);
		rd(`NORMAL_ENABLE_MASK_ADDR, 32'h8);
		wr(`NORMAL_ENABLE_CLEAR_ADDR, 32'h8);
		tick(2);
		chk({30'h0, nirq, fseen}, 32'h0);
		wr(`FAST_ENABLE_MASK_ADDR, 32'h20);
		wr(`FAST_ENABLE_CLEAR_ADDR, 32'h20);
		rd(`FAST_ENABLE_MASK_ADDR, 32'h0);
		periph <= 21'h0;
		wr(`SOFTWARE_INTERRUPT_CONFIG_ADDR, 32'h2);
		tick(2);
		rd(`NORMAL_PENDING_STATUS_ADDR, 32'h2);
		rd(`NORMAL_RAW_SIGNAL_ADDR, 32'h2);
		chk({31'h0, nirq}, 32'h1);
		wr(`SOFTWARE_INTERRUPT_CONFIG_ADDR, 32'h4);
		tick(2);
		rd(`NORMAL_PENDING_STATUS_ADDR, 32'h0);
		rd(`FAST_PENDING_STATUS_ADDR, 32'h2);
		rd(`FAST_RAW_SIGNAL_ADDR, 32'h3);
		chk({30'h0, nirq, firq}, 32'h1);
		wr(`SOFTWARE_INTERRUPT_CONFIG_ADDR, 32'h0);
		wr(`NORMAL_ENABLE_MASK_ADDR, 32'hFFFFFE);
		for (int k = 0; k < 21; k++)
		begin
			periph <= 21'h1 << k;
			tick(3);
			rd(`NORMAL_PENDING_STATUS_ADDR, 32'h4 << k);
		end
		periph <= 21'h0;
		tick(3);
		rd(`NORMAL_PENDING_STATUS_ADDR, 32'h0);
		trip <= 1'b1;
		tick(3);
		rd(`NORMAL_PENDING_STATUS_ADDR, 32'h800000);
		rd(`FAST_RAW_SIGNAL_ADDR, 32'h0);
		trip <= 1'b0;
		sync <= 1'b1;
		wr(`FAST_ENABLE_MASK_ADDR, 32'h800000);
		tick(3);
		rd(`FAST_PENDING_STATUS_ADDR, 32'h800000);
		rd(`NORMAL_ENABLE_MASK_ADDR, 32'h7FFFFE);
		rd(`FAST_RAW_SIGNAL_ADDR, 32'h800001);
		rd(`NORMAL_RAW_SIGNAL_ADDR, 32'h1);
		chk({30'h0, nirq, firq}, 32'h1);
		wr(`NORMAL_ENABLE_MASK_ADDR, 32'h1);
		tick(2);
		chk({30'h0, nirq, firq}, 32'h3);
		wr(`NORMAL_PENDING_STATUS_ADDR, 32'hFFFFFFFF);
		rd(`NORMAL_ENABLE_MASK_ADDR, 32'h1);
		rd(`NORMAL_ENABLE_CLEAR_ADDR, 32'h0);
		rd(32'hFFFF0020, 32'h0);
		stop_test();
	end
endmodule
